// >>> rtl/disk_sync_sequencer.sv
// Operation
// - Motor drive runs at one twelfth of the incoming drive frequency.
// - Each one-shot pulse advances the six-stage shift register once.
// - Inverted feedback walks the register through twelve distinct states.
// - Four motor drives, each high two steps, equally spaced around the cycle.
// - One idle step with no motor drive between consecutive drives.
// - Sync switch up forces all motor drives low; position code keeps running.
// - Position code changes six times per cycle, every second step.
// - Codes run 000, 100, 110, 111, 011, 001 as phase1 phase2 phase3.
// - Every second one-shot pulse, and only that, goes out on the host clock.
// - Host clock pulse covers the segment boundary where the code changes.
// - One-shot holds each pulse about four milliseconds.
// - Active-low valid flag accompanies the code; high while the code changes.
`timescale 1ns/1ps
`default_nettype none

module disk_sync_sequencer
  import disk_sync_pkg::*;
#(
  parameter int HOLD_CYCLES = ONESHOT_CYCLES
)(
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    drive_in,
  input  wire logic                    sync_up_in,
  output var  logic [MOTOR_PHASES-1:0] motor_drive,
  output var  logic [2:0]              phase_code,
  output var  logic                    host_clock,
  output var  logic                    code_valid_n
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

  // Johnson states have at most one place where neighbouring bits differ
  function automatic logic state_legal(input logic [STAGES-1:0] s);
    int edges;
    edges = 0;
    for (int i = 0; i < STAGES - 1; i++) begin
      if (s[i] != s[i+1]) begin
        edges++;
      end
    end
    return edges <= 1;
  endfunction

  // Position in the twelve-step cycle, 0 for the all-zero state
  function automatic logic [3:0] step_index(input logic [STAGES-1:0] s);
    logic [3:0] ones;
    ones = 4'h0;
    for (int i = 0; i < STAGES; i++) begin
      ones = ones + {3'h0, s[i]};
    end
    return s[STAGES-1] ? 4'(STEPS) - ones : ones;
  endfunction

  function automatic logic [2:0] next_code(input logic [2:0] c);
    logic [2:0] n;
    n = CODE_SEQ[0];
    for (int i = 0; i < SEGMENTS; i++) begin
      if (c == CODE_SEQ[i]) begin
        n = CODE_SEQ[(i + 1) % SEGMENTS];
      end
    end
    return n;
  endfunction

  logic drive_rise;
  logic sync_up_lvl;

  pin_conditioner u_drive_pin (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_in  (drive_in),
    .level_q (),
    .rise_q  (drive_rise)
  );

  pin_conditioner u_sync_pin (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin_in  (sync_up_in),
    .level_q (sync_up_lvl),
    .rise_q  ()
  );

  oneshot_state_type        os_state_q;
  oneshot_state_type        os_state_d;
  logic [CW-1:0]            hold_cnt_q;
  logic [CW-1:0]            hold_cnt_d;
  logic                     pass_q;
  logic                     pass_d;
  logic                     trig;
  logic [STAGES-1:0]        state_q;
  logic [STAGES-1:0]        state_d;
  logic [3:0]               step_d;
  logic [MOTOR_PHASES-1:0]  motor_d;
  logic [2:0]               phase_d;
  logic                     clock_d;

  // One-shot is not retriggerable: edges during a pulse are ignored
  assign trig = drive_rise & (os_state_q == OS_IDLE);

  always_comb begin
    os_state_d = os_state_q;
    hold_cnt_d = hold_cnt_q;
    pass_d     = pass_q;
    state_d    = state_q;
    case (os_state_q)
      OS_IDLE: begin
        if (trig) begin
          os_state_d = OS_HOLD;
          hold_cnt_d = HOLD_LAST;
        end
      end
      OS_HOLD: begin
        if (hold_cnt_q == '0) begin
          os_state_d = OS_IDLE;
        end else begin
          hold_cnt_d = hold_cnt_q - CW'(1);
        end
      end
      default: begin
        os_state_d = OS_IDLE;
      end
    endcase
    if (!state_legal(state_q)) begin
      state_d = STATE_RESET;
    end else if (trig) begin
      state_d = {state_q[STAGES-2:0], ~state_q[STAGES-1]};
    end
    // Even steps are segment boundaries, so that pulse reaches the host
    if (trig) begin
      pass_d = (state_d[0] == state_d[1]) && (state_d[2] == state_d[3]) && (state_d[4] == state_d[5]);
    end
    clock_d = (os_state_d == OS_HOLD) & pass_d;
    step_d  = step_index(state_d);
    phase_d = {state_d[PHASE1_BIT], state_d[PHASE2_BIT], state_d[PHASE3_BIT]};
    for (int m = 0; m < MOTOR_PHASES; m++) begin
      // Each phase two steps on, one idle step before the next phase: twelve steps per revolution
      motor_d[m] = ~sync_up_lvl &
                   ((step_d == 4'(MOTOR_SPACING * m)) ||
                    (step_d == 4'(MOTOR_SPACING * m + 1)));
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      os_state_q   <= OS_IDLE;
      hold_cnt_q   <= '0;
      pass_q       <= 1'b0;
      state_q      <= STATE_RESET;
      motor_drive  <= '0;
      phase_code   <= 3'h0;
      host_clock   <= 1'b0;
      code_valid_n <= 1'b0;
    end else begin
      os_state_q   <= os_state_d;
      hold_cnt_q   <= hold_cnt_d;
      pass_q       <= pass_d;
      state_q      <= state_d;
      motor_drive  <= motor_d;
      phase_code   <= phase_d;
      host_clock   <= clock_d;
      code_valid_n <= clock_d;
    end
  end

  // Checks

  logic [3:0] step_q;
  assign step_q = step_index(state_q);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_pulse_start;
    trig ##1 (os_state_q == OS_HOLD);
  endsequence

  sequence s_pulse_held;
    (os_state_q == OS_HOLD) [*8];
  endsequence

  property p_step_advance;
    trig && state_legal(state_q) |=>
      step_q == (($past(step_q) == STEP_LAST) ? 4'h0 : $past(step_q) + 4'h1);
  endproperty
  a_step_advance: assert property (p_step_advance)
    else $error("register did not advance by one step");

  property p_stay_legal;
    state_legal(state_q) |=> state_legal(state_q);
  endproperty
  a_stay_legal: assert property (p_stay_legal)
    else $error("register left the twelve-state cycle");

  property p_motor_phase;
    (step_q == 4'h3) && !$past(sync_up_lvl) && $stable(state_q) |-> motor_drive == 4'h2;
  endproperty
  a_motor_phase: assert property (p_motor_phase)
    else $error("wrong motor phase for step three");

  property p_motor_gap;
    $onehot0(motor_drive) and (((step_q % 3) == 2) && $stable(state_q) |-> motor_drive == 4'h0);
  endproperty
  a_motor_gap: assert property (p_motor_gap)
    else $error("motor drives overlap or gap step missing");

  property p_sync_off;
    $past(sync_up_lvl) |-> motor_drive == 4'h0;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("motor drive active with sync switch up");

  property p_code_even;
    $changed(phase_code) |-> step_q[0] == 1'b0;
  endproperty
  a_code_even: assert property (p_code_even)
    else $error("position code changed on an odd step");

  property p_code_order;
    $changed(phase_code) |-> phase_code == next_code($past(phase_code));
  endproperty
  a_code_order: assert property (p_code_order)
    else $error("position code out of order");

  property p_clock_source;
    $rose(host_clock) |-> $past(trig) && (step_q[0] == 1'b0);
  endproperty
  a_clock_source: assert property (p_clock_source)
    else $error("host clock not from a boundary pulse");

  property p_clock_boundary;
    $changed(phase_code) |-> host_clock && code_valid_n;
  endproperty
  a_clock_boundary: assert property (p_clock_boundary)
    else $error("code changed outside host clock pulse");

  property p_pulse_hold;
    s_pulse_start |-> s_pulse_held;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold)
    else $error("one-shot pulse ended too early");

  property p_valid_flag;
    code_valid_n |-> host_clock;
  endproperty
  a_valid_flag: assert property (p_valid_flag)
    else $error("valid flag high outside a host clock pulse");

  property p_recover;
    !state_legal(state_q) |=> state_q == STATE_RESET;
  endproperty
  a_recover: assert property (p_recover)
    else $error("illegal state not recovered");

endmodule

`default_nettype wire

// >>> rtl/disk_sync_pkg.sv
package disk_sync_pkg;

  localparam int CLK_HZ          = 25_000_000;
  localparam int ONESHOT_US      = 4000;
  // Longest hold, so rounded down to whole cycles
  localparam int ONESHOT_CYCLES  = ONESHOT_US * (CLK_HZ / 1_000_000);

  localparam int STAGES          = 6;
  localparam int STEPS           = 12;
  localparam int SEGMENTS        = 6;
  localparam int MOTOR_PHASES    = 4;
  localparam int MOTOR_SPACING   = 3;
  localparam int PIN_FLOPS       = 3;

  localparam logic [5:0] STATE_RESET = 6'h00;
  localparam logic [3:0] STEP_LAST   = 4'hB;

  // Bit positions of the position code inside the shift register
  localparam int PHASE1_BIT = 1;
  localparam int PHASE2_BIT = 3;
  localparam int PHASE3_BIT = 5;

  // Position codes in order, written phase1 phase2 phase3
  localparam logic [2:0] CODE_SEQ [SEGMENTS] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1};

  typedef enum logic {
    OS_IDLE = 1'b0,
    OS_HOLD = 1'b1
  } oneshot_state_type;

endpackage

// >>> rtl/pin_conditioner.sv
`timescale 1ns/1ps
`default_nettype none

module pin_conditioner
  import disk_sync_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output var  logic level_q,
  output var  logic rise_q
);

  logic [PIN_FLOPS-1:0] sync_q;
  logic [PIN_FLOPS-1:0] sync_d;
  logic                 level_d;
  logic                 rise_d;

  // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2
  always_comb begin
    sync_d  = {sync_q[PIN_FLOPS-2:0], pin_in};
    level_d = level_q;
    rise_d  = 1'b0;
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
      rise_d  = sync_q[2] & ~level_q;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q  <= '0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
      rise_q  <= rise_d;
    end
  end

endmodule

`default_nettype wire

// >>> testbench/drive_source_model.sv
`timescale 1ns/1ps
`default_nettype none

// Periodic trigger source; PERIOD stands for 100..150 Hz, scaled like the hold
module drive_source_model #(
  parameter int PERIOD = 40,
  parameter int WIDTH  = 6
)(
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic extra,
  output var  logic drive_out
);
  int cnt;

  always_ff @(posedge ref_clk) begin
    if (!run) begin
      cnt       <= 0;
      drive_out <= 1'b0;
    end else begin
      cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      // Extra edge lands inside the hold, where it must be refused
      drive_out <= (cnt < WIDTH) || (extra && cnt >= 2 * WIDTH && cnt < 3 * WIDTH);
    end
  end
endmodule

`default_nettype wire

// >>> testbench/viewer_disk_sync_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module viewer_disk_sync_sequencer_tb
  import disk_sync_pkg::*;
;
  localparam int HOLD = 20;

  logic                    ref_clk;
  logic                    sys_rst;
  logic                    sync_up_in;
  logic                    run;
  logic                    extra;
  logic                    drive_in;
  logic [MOTOR_PHASES-1:0] motor_drive;
  logic [2:0]              phase_code;
  logic                    host_clock;
  logic                    code_valid_n;
  int                      error_cnt = 0;
  int                      check_count = 0;
  int                      step = 0;
  logic [2:0]              codes [6] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1};

  disk_sync_sequencer #(.HOLD_CYCLES(HOLD)) i_disk_sync_sequencer (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .drive_in     (drive_in),
    .sync_up_in   (sync_up_in),
    .motor_drive  (motor_drive),
    .phase_code   (phase_code),
    .host_clock   (host_clock),
    .code_valid_n (code_valid_n)
  );

  drive_source_model i_drive_source_model (
    .ref_clk   (ref_clk),
    .run       (run),
    .extra     (extra),
    .drive_out (drive_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [3:0] exp_motor(input int s, input logic up);
    exp_motor = 4'h0;
    for (int m = 0; m < 4; m++) begin
      if (!up && (s == 3 * m || s == 3 * m + 1))
        exp_motor[m] = 1'b1;
    end
  endfunction

  task automatic apply_reset;
    run = 1'b0;
    sys_rst = 1'b1;
    @(posedge ref_clk);
    #1;
    check({motor_drive, phase_code, host_clock, code_valid_n}, 9'h000);
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    step = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    check({motor_drive, phase_code, host_clock, code_valid_n}, 9'h020);
    run = 1'b1;
  endtask

  // One trigger: outputs checked inside the pulse, pulse length counted
  task automatic do_step(input logic up);
    int         hi;
    logic       ev;
    logic [8:0] want;
    hi = 0;
    @(posedge drive_in);
    step = (step + 1) % STEPS;
    ev = (step % 2 == 0);
    want = {exp_motor(step, up), codes[step / 2], ev, ev};
    for (int c = 1; c <= 30; c++) begin
      @(posedge ref_clk);
      #1;
      if (host_clock === 1'b1)
        hi++;
      if (c == 8)
        check({motor_drive, phase_code, host_clock, code_valid_n}, want);
    end
    check(9'(hi), ev ? 9'(HOLD) : 9'h000);
  endtask

  task automatic t_full_cycle;
    for (int i = 0; i < STEPS; i++)
      do_step(1'b0);
    // Twelve triggers must bring the disk back to step zero
    check({motor_drive, phase_code, host_clock, code_valid_n}, 9'h020);
  endtask

  task automatic t_refused_and_sync;
    extra = 1'b1;
    sync_up_in = 1'b1;
    for (int i = 0; i < 6; i++)
      do_step(1'b1);
    sync_up_in = 1'b0;
    for (int i = 0; i < 6; i++)
      do_step(1'b0);
    extra = 1'b0;
  endtask

  task automatic t_mid_reset;
    for (int i = 0; i < 5; i++)
      do_step(1'b0);
    apply_reset();
    for (int i = 0; i < 3; i++)
      do_step(1'b0);
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    sync_up_in = 1'b0;
    run = 1'b0;
    extra = 1'b0;
    apply_reset();
    t_full_cycle();
    t_refused_and_sync();
    t_mid_reset();
    finish_test();
  end
endmodule

`default_nettype wire
